// ==== rtl/src_pkg.sv ====
// Shared constants for the serial ROM controller.
package src_pkg;

  // ----------------------------------------------------------
  // Memory geometry and signature
  // ----------------------------------------------------------
  localparam int SRC_AW = 7;
  localparam int SRC_DW = 8;
  localparam int SRC_MAC_BYTES = 6;
  localparam logic [7:0] SRC_SIGNATURE = 8'hA5;
  localparam logic [6:0] SRC_SIG_LOC = 7'h00;

  // ----------------------------------------------------------
  // Host command codes
  // ----------------------------------------------------------
  localparam logic [2:0] SRC_C_READ = 3'h0;
  localparam logic [2:0] SRC_C_LOCK = 3'h1;
  localparam logic [2:0] SRC_C_UNLOCK = 3'h2;
  localparam logic [2:0] SRC_C_WRITE = 3'h3;
  localparam logic [2:0] SRC_C_FILL = 3'h4;
  localparam logic [2:0] SRC_C_ERASE = 3'h5;
  localparam logic [2:0] SRC_C_WIPE = 3'h6;
  localparam logic [2:0] SRC_C_RELOAD = 3'h7;

  // ----------------------------------------------------------
  // Serial opcodes and sub-opcodes
  // ----------------------------------------------------------
  localparam logic [1:0] SRC_OP_READ = 2'h2;
  localparam logic [1:0] SRC_OP_WRITE = 2'h1;
  localparam logic [1:0] SRC_OP_ERASE = 2'h3;
  localparam logic [1:0] SRC_OP_SPECIAL = 2'h0;
  localparam logic [1:0] SRC_SUB_LOCK = 2'h0;
  localparam logic [1:0] SRC_SUB_FILL = 2'h1;
  localparam logic [1:0] SRC_SUB_WIPE = 2'h2;
  localparam logic [1:0] SRC_SUB_UNLOCK = 2'h3;

  // ----------------------------------------------------------
  // Serial clock counts and timing
  // ----------------------------------------------------------
  localparam logic [4:0] SRC_SHORT_CLKS = 5'h0A;
  localparam logic [4:0] SRC_LONG_CLKS = 5'h12;
  localparam int SRC_CLK_KHZ = 10000;
  localparam int SRC_TIMEOUT_US = 30000;
  localparam int SRC_TIMEOUT_CYC = SRC_TIMEOUT_US * SRC_CLK_KHZ / 1000;
  localparam int SRC_SCK_DIV = 4;

endpackage

// ==== rtl/src_link_engine.sv ====
// Serial frame engine running on the link clock.
`timescale 1ns/1ps
`default_nettype none
module src_link_engine
  import src_pkg::*;
#(
  parameter int SCK_DIV = SRC_SCK_DIV
) (
  // Clock and reset
  input wire logic link_clk_i,
  input wire logic reset_i,
  // Request side
  input wire logic req_tog_i,
  input wire logic abort_i,
  input wire logic [8:0] frame_i,
  input wire logic [7:0] wdata_i,
  input wire logic long_i,
  input wire logic poll_i,
  output logic ack_tog_o,
  output logic [7:0] rdata_o,
  // Pins
  output logic cs_o,
  output logic sck_o,
  output logic dout_o,
  output logic oe_o,
  input wire logic din_i
);

  typedef enum logic [1:0] {E_IDLE, E_SHIFT, E_GAP, E_POLL} src_eng_t;

  src_eng_t state;
  logic req_s1, req_s2, req_s3;
  logic abt_s1, abt_s2;
  logic din_s1, din_s2;
  logic [$clog2(SCK_DIV)-1:0] div;
  logic tick;
  logic [17:0] shreg;
  logic [4:0] bits;
  logic [4:0] nbits;
  logic poll;
  logic rd_op;

  // ----------------------------------------------------------
  // Synchronisers and divider
  // ----------------------------------------------------------
  always_ff @(posedge link_clk_i or posedge reset_i) begin
    if (reset_i) begin
      {req_s1, req_s2, req_s3} <= 3'h0;
      {abt_s1, abt_s2, din_s1, din_s2} <= 4'h0;
    end else begin
      {req_s1, req_s2, req_s3} <= {req_tog_i, req_s1, req_s2};
      {abt_s1, abt_s2, din_s1, din_s2} <= {abort_i, abt_s1, din_i, din_s1};
    end
  end

  always_ff @(posedge link_clk_i or posedge reset_i) begin
    if (reset_i) begin
      div <= '0;
    end else begin
      div <= tick ? '0 : div + 1'b1;
    end
  end

  assign tick = (div == ($clog2(SCK_DIV))'(SCK_DIV - 1));

  // ----------------------------------------------------------
  // Frame sequencer
  // ----------------------------------------------------------
  always_ff @(posedge link_clk_i or posedge reset_i) begin
    if (reset_i) begin
      state <= E_IDLE;
      {cs_o, sck_o, dout_o, oe_o, ack_tog_o, poll} <= 6'h00;
      rd_op <= 1'b0;
      shreg <= '0;
      bits <= '0;
      nbits <= '0;
      rdata_o <= '0;
    end else if (state != E_IDLE && abt_s2) begin
      // The host side has given up; release the pins and answer once.
      state <= E_IDLE;
      {cs_o, sck_o, oe_o} <= 3'h0;
      ack_tog_o <= ~ack_tog_o;
    end else begin
      unique case (state)
        E_IDLE: if (req_s2 ^ req_s3) begin
          shreg <= {1'b1, frame_i, wdata_i};
          nbits <= long_i ? SRC_LONG_CLKS : SRC_SHORT_CLKS;
          poll <= poll_i;
          rd_op <= frame_i[8:7] == SRC_OP_READ;
          bits <= '0;
          {cs_o, oe_o, dout_o} <= 3'h7;
          state <= E_SHIFT;
        end
        E_SHIFT: if (tick) begin
          if (!sck_o) begin
            sck_o <= 1'b1;
            rdata_o <= {rdata_o[6:0], din_s2};
            bits <= bits + 1'b1;
          end else begin
            sck_o <= 1'b0;
            if (bits == nbits) begin
              {cs_o, oe_o} <= 2'h0;
              state <= poll ? E_GAP : E_IDLE;
              if (!poll) begin
                ack_tog_o <= ~ack_tog_o;
              end
            end else begin
              shreg <= shreg << 1;
              dout_o <= shreg[16];
              // A read hands the shared data line to the memory after the location.
              if (rd_op && bits == SRC_SHORT_CLKS) begin
                oe_o <= 1'b0;
              end
            end
          end
        end
        E_GAP: if (tick) begin
          cs_o <= 1'b1;
          state <= E_POLL;
        end
        E_POLL: if (tick && din_s2) begin
          cs_o <= 1'b0;
          state <= E_IDLE;
          ack_tog_o <= ~ack_tog_o;
        end
      endcase
    end
  end

  // ----------------------------------------------------------
  // Checks
  // ----------------------------------------------------------
  logic sck_d;
  logic [4:0] rises;
  always_ff @(posedge link_clk_i or posedge reset_i) begin
    if (reset_i) begin
      sck_d <= 1'b0;
      rises <= '0;
    end else begin
      sck_d <= sck_o;
      if (state == E_IDLE) begin
        rises <= '0;
      end else if (sck_o && !sck_d && state == E_SHIFT) begin
        rises <= rises + 1'b1;
      end
    end
  end

  property p_clk_count;
    @(posedge link_clk_i) disable iff (reset_i)
    $fell(cs_o) && $past(state) == E_SHIFT && !$past(abt_s2)
      |-> rises == SRC_SHORT_CLKS || rises == SRC_LONG_CLKS;
  endproperty
  a_clk_count: assert property (p_clk_count) else $error("wrong clock count");

  property p_start_bit;
    @(posedge link_clk_i) disable iff (reset_i)
    $rose(cs_o) && $past(state) == E_IDLE |-> dout_o && oe_o && !sck_o;
  endproperty
  a_start_bit: assert property (p_start_bit) else $error("no start bit");

  property p_ready;
    @(posedge link_clk_i) disable iff (reset_i)
    state == E_POLL && tick && din_s2 && !abt_s2 |=> !cs_o && $changed(ack_tog_o);
  endproperty
  a_ready: assert property (p_ready) else $error("ready not taken");

  c_poll: cover property (@(posedge link_clk_i) state == E_POLL && din_s2);

endmodule
`default_nettype wire

// ==== rtl/src_serial_rom_controller.sv ====
// Serial configuration ROM controller with station address auto-load.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - At reset read location zero, check signature.
// - On signature, load six bytes into address.
// - Set loaded flag after sixth byte.
// - No signature: finish init, flag stays clear.
// - Reload command repeats check and load.
// - Busy set starts command, clear means done.
// - Read result is in data register.
// - No response in time sets timeout flag.
// - Disabled interface turns pins to outputs.
// - Erase clears the selected location.
// - Memory holds 128 locations of eight bits.
// - Ten or eighteen serial clocks per operation.
// - Fill-all writes data to every location.
// - Wipe-all erases the whole memory.
// - Lock makes memory ignore modify commands.
module src_serial_rom_controller
  import src_pkg::*;
#(
  parameter int TIMEOUT_CYC = SRC_TIMEOUT_CYC,
  parameter int SCK_DIV = SRC_SCK_DIV
) (
  // Clocks and reset
  input wire logic clk_i,
  input wire logic link_clk_i,
  input wire logic reset_i,
  input wire logic soft_reset_i,
  // Command register
  input wire logic cmd_start_i,
  input wire logic [2:0] command_code_field_i,
  input wire logic [SRC_AW-1:0] rom_location_field_i,
  input wire logic timeout_clear_i,
  output logic command_busy_flag_o,
  output logic response_timeout_flag_o,
  output logic station_addr_loaded_flag_o,
  // Data register
  input wire logic data_write_i,
  input wire logic [SRC_DW-1:0] data_wdata_i,
  output logic [SRC_DW-1:0] rom_data_register_o,
  // Station address
  output logic [31:0] station_addr_low_o,
  output logic [15:0] station_addr_high_o,
  // Pin configuration
  input wire logic rom_if_disable_i,
  input wire logic monitor_select_i,
  input wire logic [1:0] gpio_value_i,
  input wire logic [1:0] monitor_i,
  // Serial memory pins
  output logic rom_chip_select_o,
  output logic rom_serial_clock_pin_o,
  output logic rom_serial_data_pin_o,
  output logic rom_serial_data_pin_oe_o,
  input wire logic rom_serial_data_pin_i
);

  localparam int TW = $clog2(TIMEOUT_CYC + 1);

  typedef enum logic [1:0] {S_IDLE, S_ISSUE, S_WAIT, S_ABORT} src_state_t;

  src_state_t state;
  logic loading;
  logic [2:0] load_idx;
  logic [2:0] cur_code;
  logic [SRC_AW-1:0] cur_loc;
  logic [TW-1:0] tmo_cnt;
  logic req_tog;
  logic abort_lvl;
  logic [8:0] frame;
  logic f_long;
  logic f_poll;
  logic ack_s1, ack_s2, ack_s3;
  logic ack_evt;
  logic tmo_hit;
  logic tmo_set;
  logic [47:0] addr_q;
  logic e_ack;
  logic [7:0] e_rdata;
  logic e_cs, e_sck, e_dout, e_oe;
  logic [5:0] cfg_s1, cfg_s2;

  // ----------------------------------------------------------
  // Frame encoding: {long, poll, opcode, location}
  // ----------------------------------------------------------
  function automatic logic [10:0] build(input logic [2:0] c, input logic [6:0] a);
    logic [10:0] f;
    f = {2'h0, SRC_OP_SPECIAL, SRC_SUB_LOCK, 5'h00};
    unique case (c)
      SRC_C_READ: f = {2'h2, SRC_OP_READ, a};
      SRC_C_WRITE: f = {2'h3, SRC_OP_WRITE, a};
      SRC_C_ERASE: f = {2'h1, SRC_OP_ERASE, a};
      SRC_C_FILL: f = {2'h3, SRC_OP_SPECIAL, SRC_SUB_FILL, 5'h00};
      SRC_C_WIPE: f = {2'h1, SRC_OP_SPECIAL, SRC_SUB_WIPE, 5'h00};
      SRC_C_UNLOCK: f = {2'h0, SRC_OP_SPECIAL, SRC_SUB_UNLOCK, 5'h00};
      default: f = {2'h0, SRC_OP_SPECIAL, SRC_SUB_LOCK, 5'h00};
    endcase
    return f;
  endfunction

  // ----------------------------------------------------------
  // Acknowledge crossing from the link domain
  // ----------------------------------------------------------
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      {ack_s1, ack_s2, ack_s3} <= 3'h0;
    end else begin
      {ack_s1, ack_s2, ack_s3} <= {e_ack, ack_s1, ack_s2};
    end
  end

  assign ack_evt = ack_s2 ^ ack_s3;
  assign tmo_hit = state == S_WAIT && !ack_evt && tmo_cnt == TW'(TIMEOUT_CYC - 1);
  assign tmo_set = state == S_ABORT && ack_evt;

  // ----------------------------------------------------------
  // Command sequencer
  // ----------------------------------------------------------
  // Frame words are held steady from the request toggle until the
  // answer returns, so the link side may sample them late.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state <= S_ISSUE;
      loading <= 1'b1;
      load_idx <= '0;
      cur_code <= '0;
      cur_loc <= '0;
      req_tog <= 1'b0;
      frame <= '0;
      {f_long, f_poll} <= 2'h0;
    end else begin
      unique case (state)
        S_IDLE: begin
          if (soft_reset_i) begin
            loading <= 1'b1;
            load_idx <= '0;
            state <= S_ISSUE;
          end else if (cmd_start_i) begin
            cur_code <= command_code_field_i;
            cur_loc <= rom_location_field_i;
            loading <= command_code_field_i == SRC_C_RELOAD;
            load_idx <= '0;
            state <= S_ISSUE;
          end
        end
        S_ISSUE: begin
          if (loading) begin
            {f_long, f_poll, frame} <= build(SRC_C_READ, SRC_SIG_LOC + 7'(load_idx));
          end else begin
            {f_long, f_poll, frame} <= build(cur_code, cur_loc);
          end
          req_tog <= ~req_tog;
          state <= S_WAIT;
        end
        S_WAIT: begin
          if (ack_evt) begin
            if (loading && load_idx == 3'h0 && e_rdata != SRC_SIGNATURE) begin
              state <= S_IDLE;
            end else if (loading && load_idx != 3'(SRC_MAC_BYTES)) begin
              load_idx <= load_idx + 1'b1;
              state <= S_ISSUE;
            end else begin
              state <= S_IDLE;
            end
          end else if (tmo_hit) begin
            state <= S_ABORT;
          end
        end
        S_ABORT: if (ack_evt) begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------
  // Response timer, counted from the start of each frame
  // ----------------------------------------------------------
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      tmo_cnt <= '0;
      abort_lvl <= 1'b0;
    end else begin
      tmo_cnt <= state == S_WAIT ? tmo_cnt + 1'b1 : '0;
      if (tmo_hit) begin
        abort_lvl <= 1'b1;
      end else if (tmo_set) begin
        abort_lvl <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------
  // Host visible flags
  // ----------------------------------------------------------
  // Busy also covers the reset-time load; the sequencer itself ignores
  // starts outside S_IDLE, which is what keeps a command off the top of it.
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      command_busy_flag_o <= 1'b1;
    end else if (state == S_IDLE && (cmd_start_i || soft_reset_i)) begin
      command_busy_flag_o <= 1'b1;
    end else if ((state == S_WAIT || state == S_ABORT) && ack_evt) begin
      if (state == S_ABORT || !loading || load_idx == 3'(SRC_MAC_BYTES)
          || (load_idx == 3'h0 && e_rdata != SRC_SIGNATURE)) begin
        command_busy_flag_o <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      response_timeout_flag_o <= 1'b0;
    end else if (tmo_set) begin
      response_timeout_flag_o <= 1'b1;
    end else if (timeout_clear_i) begin
      response_timeout_flag_o <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      station_addr_loaded_flag_o <= 1'b0;
    end else if (state == S_ISSUE && loading && load_idx == 3'h0) begin
      station_addr_loaded_flag_o <= 1'b0;
    end else if (state == S_WAIT && ack_evt && loading
                 && load_idx == 3'(SRC_MAC_BYTES)) begin
      station_addr_loaded_flag_o <= 1'b1;
    end
  end

  // ----------------------------------------------------------
  // Data register and station address
  // ----------------------------------------------------------
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rom_data_register_o <= '0;
    end else if (state == S_WAIT && ack_evt && !loading && cur_code == SRC_C_READ) begin
      rom_data_register_o <= e_rdata;
    end else if (data_write_i && !command_busy_flag_o) begin
      rom_data_register_o <= data_wdata_i;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      addr_q <= '0;
    end else if (state == S_WAIT && ack_evt && loading && load_idx != 3'h0) begin
      addr_q[8 * (load_idx - 3'h1) +: 8] <= e_rdata;
    end
  end

  assign station_addr_low_o = addr_q[31:0];
  assign station_addr_high_o = addr_q[47:32];

  // ----------------------------------------------------------
  // Link side engine
  // ----------------------------------------------------------
  src_link_engine #(
    .SCK_DIV(SCK_DIV)
  ) u_engine (
    .link_clk_i(link_clk_i),
    .reset_i(reset_i),
    .req_tog_i(req_tog),
    .abort_i(abort_lvl),
    .frame_i(frame),
    .wdata_i(rom_data_register_o),
    .long_i(f_long),
    .poll_i(f_poll),
    .ack_tog_o(e_ack),
    .rdata_o(e_rdata),
    .cs_o(e_cs),
    .sck_o(e_sck),
    .dout_o(e_dout),
    .oe_o(e_oe),
    .din_i(rom_serial_data_pin_i)
  );

  // ----------------------------------------------------------
  // Pin configuration, link domain
  // ----------------------------------------------------------
  // Configuration bits are quasi-static levels, so a two stage
  // synchroniser per bit is enough; a change mid-frame corrupts it.
  always_ff @(posedge link_clk_i or posedge reset_i) begin
    if (reset_i) begin
      cfg_s1 <= '0;
      cfg_s2 <= '0;
    end else begin
      cfg_s1 <= {rom_if_disable_i, monitor_select_i, gpio_value_i, monitor_i};
      cfg_s2 <= cfg_s1;
    end
  end

  always_ff @(posedge link_clk_i or posedge reset_i) begin
    if (reset_i) begin
      rom_chip_select_o <= 1'b0;
      rom_serial_clock_pin_o <= 1'b0;
      rom_serial_data_pin_o <= 1'b0;
      rom_serial_data_pin_oe_o <= 1'b0;
    end else if (cfg_s2[5]) begin
      rom_chip_select_o <= 1'b0;
      {rom_serial_clock_pin_o, rom_serial_data_pin_o} <= cfg_s2[4] ? cfg_s2[1:0] : cfg_s2[3:2];
      rom_serial_data_pin_oe_o <= 1'b1;
    end else begin
      rom_chip_select_o <= e_cs;
      rom_serial_clock_pin_o <= e_sck;
      rom_serial_data_pin_o <= e_dout;
      rom_serial_data_pin_oe_o <= e_oe;
    end
  end

  // ----------------------------------------------------------
  // Checks
  // ----------------------------------------------------------
  property p_sig_read;
    @(posedge clk_i) disable iff (reset_i)
    state == S_ISSUE && loading && load_idx == 3'h0
      |=> frame == {SRC_OP_READ, SRC_SIG_LOC} && f_long && state == S_WAIT;
  endproperty
  a_sig_read: assert property (p_sig_read) else $error("bad signature read");

  property p_byte_store;
    @(posedge clk_i) disable iff (reset_i)
    state == S_WAIT && ack_evt && loading && load_idx != 3'h0
      |=> 8'(addr_q >> (8 * ($past(load_idx) - 3'h1))) == $past(e_rdata);
  endproperty
  a_byte_store: assert property (p_byte_store) else $error("byte not stored");

  property p_loaded;
    @(posedge clk_i) disable iff (reset_i)
    $rose(station_addr_loaded_flag_o)
      |-> $past(load_idx) == 3'h6 && $past(loading) && $fell(command_busy_flag_o);
  endproperty
  a_loaded: assert property (p_loaded) else $error("loaded flag early");

  property p_no_sig;
    @(posedge clk_i) disable iff (reset_i)
    state == S_WAIT && ack_evt && loading && load_idx == 3'h0 && e_rdata != SRC_SIGNATURE
      |=> state == S_IDLE && !station_addr_loaded_flag_o && !command_busy_flag_o;
  endproperty
  a_no_sig: assert property (p_no_sig) else $error("missing signature mishandled");

  property p_start;
    @(posedge clk_i) disable iff (reset_i)
    state == S_IDLE && cmd_start_i && !soft_reset_i
      |=> command_busy_flag_o && state == S_ISSUE ##1 state == S_WAIT;
  endproperty
  a_start: assert property (p_start) else $error("command not started");

  property p_read_data;
    @(posedge clk_i) disable iff (reset_i)
    $fell(command_busy_flag_o) && $past(cur_code) == SRC_C_READ && !$past(loading)
      && $past(state) == S_WAIT |-> rom_data_register_o == $past(e_rdata);
  endproperty
  a_read_data: assert property (p_read_data) else $error("read data missing");

  property p_timeout;
    @(posedge clk_i) disable iff (reset_i)
    tmo_hit |=> abort_lvl && state == S_ABORT;
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout not taken");

  property p_tflag;
    @(posedge clk_i) disable iff (reset_i)
    tmo_set |=> response_timeout_flag_o && !command_busy_flag_o && !abort_lvl;
  endproperty
  a_tflag: assert property (p_tflag) else $error("timeout flag missing");

  property p_pin_mux;
    @(posedge link_clk_i) disable iff (reset_i)
    cfg_s2[5] |=> !rom_chip_select_o && rom_serial_data_pin_oe_o;
  endproperty
  a_pin_mux: assert property (p_pin_mux) else $error("pins not released");

  c_loaded: cover property (@(posedge clk_i) $rose(station_addr_loaded_flag_o));
  c_timeout: cover property (@(posedge clk_i) $rose(response_timeout_flag_o));
  c_read: cover property (@(posedge clk_i) state == S_WAIT && ack_evt && cur_code == SRC_C_READ);
  c_gpio: cover property (@(posedge link_clk_i) cfg_s2[5]);

endmodule
`default_nettype wire

// ==== tb/src_rom_model.sv ====
// Behavioural serial memory on the far side of the ROM pins.
`timescale 1ns/1ps
`default_nettype none
module src_rom_model
  import src_pkg::*;
(
  // Pins
  input wire logic cs_i,
  input wire logic sck_i,
  input wire logic dout_i,
  input wire logic oe_i,
  // Fault control
  input wire logic mute_i,
  output logic din_o
);
  logic [7:0] mem [128];
  logic [31:0] sh = 0;
  logic [9:0] hd = 0;
  logic lock = 1;
  logic poll = 0, rdy = 0, bit_q = 0, pat = 0;
  int n = 0;
  initial for (int i = 0; i < 128; i++) mem[i] = (i == 0) ? 8'hA5 : 8'(i * 7 + 3);
  // A released line toggles, so a stale level can never pass for data.
  always #45 pat = ~pat;
  assign din_o = oe_i ? dout_i : (cs_i && poll) ? rdy : (cs_i && n >= 10) ? bit_q : pat;
  always @(posedge cs_i) n = 0;
  always @(posedge sck_i) if (cs_i) begin
    poll = 0;
    sh = {sh[30:0], dout_i};
    n++;
    if (n == 10) hd = sh[9:0];
  end
  always @(negedge sck_i) if (cs_i && n >= 10 && n < 18) bit_q = mem[hd[6:0]][17 - n];
  always @(negedge cs_i) if (n == 10 || n == 18) begin
    case (hd[8:7])
      SRC_OP_ERASE: if (!lock) mem[hd[6:0]] = 8'hFF;
      SRC_OP_WRITE: if (!lock) mem[hd[6:0]] = sh[7:0];
      SRC_OP_SPECIAL: case (hd[6:5])
        SRC_SUB_LOCK: lock = 1;
        SRC_SUB_UNLOCK: lock = 0;
        default: for (int i = 0; i < 128; i++) if (!lock) mem[i] = hd[5] ? sh[7:0] : 8'hFF;
      endcase
      default: ;
    endcase
    poll = hd[8:7] != SRC_OP_READ && !(hd[8:7] == SRC_OP_SPECIAL && hd[6] == hd[5]);
    rdy = 0;
    rdy <= #3000 !mute_i;
  end
endmodule
`default_nettype wire

// ==== tb/src_serial_rom_controller_tb.sv ====
// Self-checking bench for the serial ROM controller.
`timescale 1ns/1ps
`default_nettype none
module src_serial_rom_controller_tb;
  import src_pkg::*;
  logic clk = 0, lclk = 0, rst = 1, srst = 0, go = 0, tclr = 0, dw = 0;
  logic dis = 0, msel = 0, mute = 0;
  logic [2:0] code = 0;
  logic [6:0] loc = 0, a;
  logic [7:0] wd = 0, d, rdat;
  logic [1:0] gv = 0, mv = 0;
  logic busy, tmo, ld, cs, sck, dout, oe, din;
  logic [31:0] lo, rs = 32'h9bb0_fa30;
  logic [15:0] hi;
  logic [7:0] ex [128];
  int n_fail = 0, checks_done = 0, cyc = 0;
  initial forever #50 clk = ~clk;
  initial begin
    #3;
    forever #7.5 lclk = ~lclk;
  end
  src_serial_rom_controller #(.TIMEOUT_CYC(2000)) i_dut (.clk_i(clk), .link_clk_i(lclk),
    .reset_i(rst), .soft_reset_i(srst), .cmd_start_i(go), .command_code_field_i(code),
    .rom_location_field_i(loc), .timeout_clear_i(tclr), .command_busy_flag_o(busy),
    .response_timeout_flag_o(tmo), .station_addr_loaded_flag_o(ld), .data_write_i(dw),
    .data_wdata_i(wd), .rom_data_register_o(rdat), .station_addr_low_o(lo),
    .station_addr_high_o(hi), .rom_if_disable_i(dis), .monitor_select_i(msel),
    .gpio_value_i(gv), .monitor_i(mv), .rom_chip_select_o(cs), .rom_serial_clock_pin_o(sck),
    .rom_serial_data_pin_o(dout), .rom_serial_data_pin_oe_o(oe), .rom_serial_data_pin_i(din));
  src_rom_model i_mem (.cs_i(cs), .sck_i(sck), .dout_i(dout), .oe_i(oe), .mute_i(mute),
    .din_o(din));
  function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  task automatic chk(input logic [47:0] g, input logic [47:0] e);
    checks_done++;
    if (g !== e) begin
      n_fail++;
      $display("Error at %0t: got %h, expected %h", $time, g, e);
    end
  endtask
  task automatic results();
    $display("Checks %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic step();
    @(posedge clk);
    #1;
  endtask
  // Bounded wait; a hang here shows up as a mismatch, not a stall.
  task automatic idle();
    int k;
    for (k = 0; k < 5000 && busy !== 1'b0; k++) step();
    if (k == 5000) chk(1, 0);
  endtask
  task automatic cmd(input logic [2:0] c, input logic [6:0] l);
    code = c;
    loc = l;
    go = 1;
    step();
    go = 0;
    idle();
  endtask
  task automatic wdat(input logic [7:0] v);
    wd = v;
    dw = 1;
    step();
    dw = 0;
  endtask
  task automatic rd(input logic [6:0] l);
    cmd(SRC_C_READ, l);
    chk(rdat, ex[l]);
  endtask
  task automatic macchk();
    chk({hi, lo}, {ex[6], ex[5], ex[4], ex[3], ex[2], ex[1]});
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      results();
    end
  end
  initial begin
    for (int i = 0; i < 128; i++) ex[i] = (i == 0) ? 8'hA5 : 8'(i * 7 + 3);
    repeat (4) @(posedge clk);
    #1 rst = 0;
    idle();
    chk(ld, 1);
    macchk();
    a = 7'(rnd());
    rd(a);
    d = 8'(rnd());
    wdat(d);
    cmd(SRC_C_WRITE, a);
    rd(a);
    cmd(SRC_C_UNLOCK, 0);
    wdat(d);
    cmd(SRC_C_WRITE, a);
    ex[a] = d;
    rd(a);
    cmd(SRC_C_ERASE, a);
    ex[a] = 8'hFF;
    rd(a);
    cmd(SRC_C_LOCK, 0);
    wdat(~d);
    cmd(SRC_C_WRITE, a);
    rd(a);
    cmd(SRC_C_UNLOCK, 0);
    d = 8'(rnd());
    wdat(d);
    cmd(SRC_C_FILL, 0);
    for (int i = 0; i < 128; i++) ex[i] = d;
    rd(0);
    rd(127);
    cmd(SRC_C_WIPE, 0);
    for (int i = 0; i < 128; i++) ex[i] = 8'hFF;
    rd(7'(rnd()));
    cmd(SRC_C_RELOAD, 0);
    chk(ld, 0);
    for (int i = 0; i < 7; i++) begin
      ex[i] = (i == 0) ? 8'hA5 : 8'(rnd());
      wdat(ex[i]);
      cmd(SRC_C_WRITE, 7'(i));
    end
    cmd(SRC_C_RELOAD, 0);
    chk(ld, 1);
    macchk();
    srst = 1;
    step();
    srst = 0;
    idle();
    chk(ld, 1);
    mute = 1;
    cmd(SRC_C_ERASE, a);
    chk(tmo, 1);
    mute = 0;
    tclr = 1;
    step();
    tclr = 0;
    step();
    chk(tmo, 0);
    dis = 1;
    gv = 2'(rnd());
    mv = ~gv;
    repeat (6) step();
    chk({oe, sck, dout}, {1'b1, gv});
    msel = 1;
    repeat (6) step();
    chk({sck, dout}, mv);
    results();
  end
endmodule
`default_nettype wire
